// ---- bench/spi_eeprom_chk.sv ----
module spi_eeprom_chk #(
	parameter int ADDR_W       = 13,
	parameter int WRITE_CYCLES = 200
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// serial pins seen at the block
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic so,
	input wire logic so_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	// one domain, so one clocking and one disable
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// output quiet at every reset exit
	a_reset_quiet: assert property ($fell(rst) |-> !so_oe && !so)
		else $error("output active after reset");
	// deselected: released within sync plus one register
	a_desel_idle: assert property (cs_n [*4] |-> !so_oe)
		else $error("output driven while deselected");
	// paused: released within sync plus one register
	a_pause_idle: assert property (!hold_n [*4] |-> !so_oe)
		else $error("output driven while paused");
	// any drive traces back to select and no pause
	a_oe_cause: assert property (
		so_oe |-> !$past(cs_n, 3) && $past(hold_n, 3))
		else $error("output driven without cause");
	// drive starts just after the last command rise (status read) or the last address rise (array read)
	a_oe_at_rise: assert property (
		$rose(so_oe) && $past(hold_n, 5) |-> $past(sck, 2))
		else $error("output enabled away from a rise");
	// data moves only after a falling edge
	a_so_on_fall: assert property (
		so_oe && $past(so_oe) && $changed(so) |-> !$past(sck, 2))
		else $error("output moved without a fall");
	// a rise leaves the data bit alone
	a_so_held: assert property (
		$rose(sck) && !cs_n && hold_n |=> $stable(so) [*4])
		else $error("output moved after a rise");
	// nothing driven in the first 8 cycles after select falls
	a_cmd_quiet: assert property ($fell(cs_n) |=> !so_oe [*8])
		else $error("output during command byte");

	// main scenarios reached
	c_read_out: cover property ($rose(so_oe));
	c_paused: cover property ($fell(hold_n) && !cs_n);
	c_guard_pin: cover property ($fell(wp_n) && !cs_n);
endmodule // spi_eeprom_chk

bind spi_eeprom_command_protect spi_eeprom_chk #(
	.ADDR_W(ADDR_W),
	.WRITE_CYCLES(WRITE_CYCLES)
) chk (
	.ref_clk(ref_clk),
	.rst(rst),
	.cs_n(cs_n),
	.sck(sck),
	.si(si),
	.hold_n(hold_n),
	.wp_n(wp_n),
	.so(so),
	.so_oe(so_oe)
);

// ---- bench/spi_host.sv ----
`include "eeprom_defs.svh"

module spi_host (
	// clock
	input  wire logic ref_clk,
	// pins toward the device
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      hold_n,
	output logic      wp_n,
	input  wire logic so,
	input  wire logic so_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle: deselected, clock parked low, no pause
	initial begin
		{cs_n, sck, si, hold_n, wp_n} = `PIN_IDLE;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// select, leaving room for the pin sync
	task automatic open_f();
		cs_n <= 1'h0;
		tick(4);
	endtask

	// msb first, mode 0: 4 cycles low, 4 high
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck <= 1'h0;
			si  <= tx[i];
			tick(3);
			// a released line reads inverted, so stale data cannot pass
			@(negedge ref_clk) rx[i] = so_oe ? so : ~so;
			@(posedge ref_clk) sck <= 1'h1;
			tick(4);
		end
	endtask

	// deselect only on a whole byte, clock low first
	task automatic close_f();
		sck  <= 1'h0;
		tick(4);
		cs_n <= 1'h1;
		si   <= ~si; // released line shows no stale level
		tick(6);
	endtask

	// pause with clock low, wiggle data, resume with clock low
	task automatic pause(output logic oe_seen);
		sck    <= 1'h0;
		tick(4);
		hold_n <= 1'h0;
		repeat (6) begin
			si <= ~si;
			tick(2);
		end
		oe_seen = so_oe;
		hold_n  <= 1'h1;
		tick(4);
	endtask

	// protect pin level
	task automatic guard_pin(input logic v);
		wp_n <= v;
	endtask
endmodule // spi_host

// ---- bench/tb_top.sv ----
`include "eeprom_defs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WC    = 400;   // >= 64, outlasts two status polls
	localparam int LIMIT = 60000; // hang cut-off in cycles
	// device pins
	logic       ref_clk;
	logic       rst;
	logic       cs_n;
	logic       sck;
	logic       si;
	logic       hold_n;
	logic       wp_n;
	logic       so;
	logic       so_oe;
	// bookkeeping
	int         n_fail  = 0;
	int         n_tests = 0;
	int         cyc     = 0;
	logic [7:0] r;

	// 25 MHz
	initial begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end

	spi_host host (
		.ref_clk(ref_clk),
		.cs_n(cs_n),
		.sck(sck),
		.si(si),
		.hold_n(hold_n),
		.wp_n(wp_n),
		.so(so),
		.so_oe(so_oe)
	);

	spi_eeprom_command_protect #(
		.WRITE_CYCLES(WC)
	) uut (
		.ref_clk(ref_clk),
		.rst(rst),
		.cs_n(cs_n),
		.sck(sck),
		.si(si),
		.hold_n(hold_n),
		.wp_n(wp_n),
		.so(so),
		.so_oe(so_oe)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// one-byte command frame
	task automatic cmd(input logic [7:0] op);
		host.open_f();
		host.xbyte(op, r);
		host.close_f();
	endtask

	task automatic st_read(output logic [7:0] s);
		host.open_f();
		host.xbyte(`OP_STATE_READ, s);
		host.xbyte(8'h00, s);
		host.close_f();
	endtask

	task automatic st(input logic [7:0] e);
		logic [7:0] s;
		st_read(s);
		check(s, e);
	endtask

	// poll busy, bounded
	task automatic wait_rdy();
		logic [7:0] s;
		for (int i = 0; i < 40; i++) begin
			st_read(s);
			if (s[`BIT_BUSY] === 1'h0)
				break;
		end
	endtask

	// optional allow frame, write frame, optional wait
	task automatic wr(input bit en, input bit w, input logic [7:0] op,
		input logic [15:0] a, input logic [7:0] d[$]);
		if (en)
			cmd(`OP_WRITE_ALLOW);
		host.open_f();
		host.xbyte(op, r);
		if (op == `OP_ARRAY_WRITE) begin
			host.xbyte(a[15:8], r);
			host.xbyte(a[7:0], r);
		end
		foreach (d[i])
			host.xbyte(d[i], r);
		host.close_f();
		if (w)
			wait_rdy();
	endtask

	// read and compare; p pauses mid-address and after each byte
	task automatic rd(input logic [15:0] a, input logic [7:0] e[$],
		input bit p);
		logic oe;
		host.open_f();
		host.xbyte(`OP_ARRAY_READ, r);
		host.xbyte(a[15:8], r);
		if (p)
			host.pause(oe);
		host.xbyte(a[7:0], r);
		foreach (e[i]) begin
			host.xbyte(8'h00, r);
			check(r, e[i]);
			if (p) begin
				host.pause(oe);
				check({7'h00, oe}, 8'h00);
			end
		end
		host.close_f();
	endtask

	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_fail++;
			$display("ERROR %0t: run hung", $time);
			test_done();
		end
	end

	initial begin
		rst = 1'h1;
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		check({7'h00, so_oe}, 8'h00);
		st(8'h00);
		$display("test power-up done");
		cmd(`OP_WRITE_ALLOW);
		st(8'h02);
		cmd(`OP_WRITE_FORBID);
		st(8'h00);
		host.open_f();
		host.xbyte(`OP_WRITE_ALLOW, r);
		host.xbyte(`OP_ARRAY_WRITE, r);
		host.xbyte(8'h1F, r);
		host.xbyte(8'h3E, r);
		host.xbyte(8'h55, r);
		host.close_f();
		st(8'h02);
		$display("test latch done");
		wr(0, 0, `OP_ARRAY_WRITE, 16'h1F3E, '{8'h11, 8'h22, 8'h33, 8'h44});
		st(8'h03);
		cmd(`OP_WRITE_FORBID);
		st(8'h03);
		wait_rdy();
		st(8'h00);
		rd(16'h1F3E, '{8'h11, 8'h22}, 0);
		rd(16'h1F00, '{8'h33, 8'h44}, 1);
		wr(1, 1, `OP_ARRAY_WRITE, 16'h1FFF, '{8'h5A});
		wr(1, 1, `OP_ARRAY_WRITE, 16'h0000, '{8'hC3});
		rd(16'hFFFF, '{8'h5A, 8'hC3}, 0);
		wr(0, 1, `OP_ARRAY_WRITE, 16'h0000, '{8'h77});
		rd(16'h0000, '{8'hC3}, 0);
		$display("test array done");
		wr(1, 1, `OP_ARRAY_WRITE, 16'h1800, '{8'hA0});
		wr(1, 1, `OP_ARRAY_WRITE, 16'h1000, '{8'hB0});
		wr(1, 1, `OP_STATE_WRITE, 16'h0000, '{8'h77});
		st(8'h04);
		wr(1, 1, `OP_ARRAY_WRITE, 16'h1800, '{8'h01});
		rd(16'h1800, '{8'hA0}, 0);
		wr(1, 1, `OP_ARRAY_WRITE, 16'h1000, '{8'h01});
		rd(16'h1000, '{8'h01}, 0);
		wr(1, 1, `OP_STATE_WRITE, 16'h0000, '{8'h08});
		wr(1, 1, `OP_ARRAY_WRITE, 16'h1000, '{8'h02});
		rd(16'h1000, '{8'h01}, 0);
		wr(1, 1, `OP_STATE_WRITE, 16'h0000, '{8'h8C});
		st(8'h8C);
		wr(1, 1, `OP_ARRAY_WRITE, 16'h0000, '{8'h03});
		rd(16'h0000, '{8'hC3}, 0);
		$display("test region done");
		host.guard_pin(1'h0);
		wr(1, 0, `OP_STATE_WRITE, 16'h0000, '{8'h00});
		st(8'h8E);
		host.guard_pin(1'h1);
		host.open_f();
		host.xbyte(`OP_STATE_WRITE, r);
		host.xbyte(8'h00, r);
		host.guard_pin(1'h0);
		host.tick(6);
		host.guard_pin(1'h1);
		host.tick(6);
		host.close_f();
		st(8'h8E);
		wr(1, 1, `OP_STATE_WRITE, 16'h0000, '{8'h00});
		st(8'h00);
		wr(1, 1, `OP_STATE_WRITE, 16'h0000, '{8'h04});
		cmd(`OP_WRITE_ALLOW);
		rst <= 1'h1;
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		st(8'h04);
		$display("test guard done");
		test_done();
	end
endmodule // tb_top

// ---- logic/eeprom_defs.svh ----
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// command opcodes, first byte after select
`define OP_WRITE_ALLOW  8'h06
`define OP_WRITE_FORBID 8'h04
`define OP_STATE_READ   8'h05
`define OP_STATE_WRITE  8'h01
`define OP_ARRAY_READ   8'h03
`define OP_ARRAY_WRITE  8'h02

// status bit positions
`define BIT_BUSY        0
`define BIT_LATCH       1
`define BIT_SEL_LO      2
`define BIT_SEL_HI      3
`define BIT_GUARD       7

// last bit index of each serial phase
`define CMD_LAST        4'h7
`define ADDR_LAST       4'hF
`define BYTE_LAST       4'h7

// array geometry: larger variant, 64-byte page
`define MEM_ADDR_W      13
`define PAGE_W          6
`define BUF_DEPTH       2

// write cycle time, longest figure, rounded down to cycles
`define WRITE_TIME_US   10000
`define CLK_MHZ         25
`define WRITE_CYCLES    (`WRITE_TIME_US * `CLK_MHZ)

// nonvolatile protection bits as shipped
`define NV_GUARD_INIT   1'h0
`define NV_SEL_INIT     2'h0

// idle pin levels {cs_n, sck, si, hold_n, wp_n}
`define PIN_IDLE        5'h13

`endif

// ---- logic/eeprom_pkg.sv ----
package eeprom_pkg;

	// serial position within a select period
	typedef enum {
		PH_CMD, PH_ADDR, PH_READ, PH_STAT, PH_WDATA, PH_SDATA, PH_SKIP
	} phase_type;

	// what the self-timed cycle is programming
	typedef enum {WK_NONE, WK_ARRAY, WK_STATUS} write_kind_type;

	// pins that enter from the host side
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic hold_n;
		logic wp_n;
	} pin_type;

	// status byte as shifted out
	typedef struct packed {
		logic       guard;
		logic [2:0] rsv;
		logic       sel_hi;
		logic       sel_lo;
		logic       latch;
		logic       busy;
	} status_type;

endpackage

// ---- logic/pair_buffer.sv ----
module pair_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] slot [DEPTH]; // storage
	logic [PW-1:0]    wr_ptr;       // next slot to fill
	logic [PW-1:0]    rd_ptr;       // oldest slot
	logic [PW:0]      fill;         // words held
	logic             push;
	logic             pop;

	assign in_ready  = fill != (PW+1)'(DEPTH);
	assign out_valid = fill != '0;
	assign out_data  = slot[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointers and fill count; flush drops stale words
	always_ff @(posedge clk) begin
		if (rst || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + PW'(1);
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + PW'(1);
			fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// data slots need no reset
	always_ff @(posedge clk) begin
		if (push)
			slot[wr_ptr] <= in_data;
	end

endmodule // pair_buffer

// ---- logic/pin_sync.sv ----
module pin_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE  = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// asynchronous levels in, clean levels out
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] synced
);

	logic [WIDTH-1:0] stage; // first flop, read only by the second

	// two flops against metastability
	always_ff @(posedge clk) begin
		if (rst) begin
			stage  <= IDLE;
			synced <= IDLE;
		end else begin
			stage  <= raw;
			synced <= stage;
		end
	end

endmodule // pin_sync

// ---- logic/spi_eeprom_command_protect.sv ----
// Contract
// - paused: SO released, SI edges ignored
// - status bit 0 shows busy, read only
// - region bits pick none, quarter, half, all
// - protected region is never written
// - guard bit plus low pin blocks status writes
// - writes need the write latch set
// - latch set by allow, cleared by forbid
// - power-up: latch clear, standby, SO released
// - latch set by allow takes effect only after deselect
// - read: command, 16-bit address, then data
// - read address increments and wraps to zero
// - status readable any time, even busy
// - byte write programs only after deselect
// - while busy, only status read is obeyed
// - page write wraps within low six bits
// - finished write cycle clears the latch
// - status write alters bits 7, 3, 2 only
// - protected address skips its write
// - region bits survive power cycles
// - first byte is command, six opcodes
// - SI sampled on rise, SO changes on fall
// - pin drop while selected aborts status write when guard bit set
`include "eeprom_defs.svh"

module spi_eeprom_command_protect #(
	parameter int ADDR_W       = `MEM_ADDR_W,
	parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// serial pins from the host
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic si,
	input  wire logic hold_n,
	input  wire logic wp_n,
	// serial data out, three-state
	output logic      so,
	output logic      so_oe
);

	localparam int PAGE_W = `PAGE_W;
	localparam int PAGE_N = 2 ** PAGE_W;
	localparam int BW     = $clog2(WRITE_CYCLES + 1);

	// array protection decode, used at capture and at commit
	function automatic logic is_protected(
		input logic [ADDR_W-1:0] a,
		input logic [1:0]        sel
	);
		unique case (sel)
			2'h0: is_protected = 1'b0;
			2'h1: is_protected = &a[ADDR_W-1:ADDR_W-2];
			2'h2: is_protected = a[ADDR_W-1];
			2'h3: is_protected = 1'b1;
		endcase
	endfunction

	eeprom_pkg::pin_type        pins_raw;     // pins as they arrive
	eeprom_pkg::pin_type        pins;         // pins after two flops
	logic                       sck_q;        // last sampled clock
	logic                       cs_q;         // last sampled select
	logic                       selected;
	logic                       paused;
	logic                       hw_guard;     // hardware protection on
	logic                       sck_rise;
	logic                       sck_fall;
	logic                       cs_rise;
	eeprom_pkg::phase_type      phase;
	eeprom_pkg::phase_type      next_phase;
	logic [3:0]                 in_cnt;       // bit within phase
	logic [15:0]                sr;           // input shifter
	logic [15:0]                next_sr;
	logic [7:0]                 op;           // byte just completed
	logic                       cmd_done;
	logic                       addr_done;
	logic                       byte_in;
	logic                       is_read;
	logic                       cmd_write_allow_arm;     // allow seen this period
	logic                       got_byte;
	logic                       abort;        // pin dropped mid status write
	logic                       write_latch;
	logic                       pin_guard_enable = `NV_GUARD_INIT;
	logic                       region_sel_hi    = 1'(`NV_SEL_INIT >> 1);
	logic                       region_sel_lo    = 1'(`NV_SEL_INIT & 2'h1);
	logic [7:0]                 stat_new;     // byte for status write
	eeprom_pkg::status_type     stat;
	eeprom_pkg::write_kind_type kind;
	logic                       busy;
	logic [BW-1:0]              busy_cnt;
	logic                       cycle_done;
	logic                       start_array;
	logic                       start_status;
	logic [PAGE_W:0]            commit_idx;   // msb set when page done
	logic [ADDR_W-1:0]          commit_addr;
	logic [ADDR_W-1:0]          wr_addr;
	logic [PAGE_N-1:0]          pmask;        // page bytes to program
	logic [7:0]                 page_mem [PAGE_N];
	logic [7:0]                 mem      [2 ** ADDR_W];
	logic [ADDR_W-1:0]          fetch_addr;
	logic                       buf_push_ok;
	logic                       buf_valid;
	logic [7:0]                 buf_data;
	logic                       buf_pop;
	logic                       out_phase;
	logic [2:0]                 out_cnt;      // bit within output byte
	logic [6:0]                 out_sr;
	logic [7:0]                 load_byte;

	assign pins_raw = '{cs_n: cs_n, sck: sck, si: si,
		hold_n: hold_n, wp_n: wp_n};

	// every pin crosses in through two flops
	pin_sync #(
		.WIDTH ($bits(eeprom_pkg::pin_type)),
		.IDLE  (`PIN_IDLE)
	) u_sync (
		.clk    (ref_clk),
		.rst    (rst),
		.raw    (pins_raw),
		.synced (pins)
	);

	// edge history of clock and select
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sck_q <= 1'b0;
			cs_q  <= 1'b1;
		end else begin
			sck_q <= pins.sck;
			cs_q  <= pins.cs_n;
		end
	end

	assign selected = !pins.cs_n;
	assign paused   = !pins.hold_n;
	assign hw_guard = pin_guard_enable && !pins.wp_n;
	// edges during a pause are dropped, position is kept
	assign sck_rise = selected && !paused && pins.sck && !sck_q;
	assign sck_fall = selected && !paused && !pins.sck && sck_q;
	assign cs_rise  = pins.cs_n && !cs_q;
	assign next_sr  = {sr[14:0], pins.si};
	assign op       = next_sr[7:0];
	assign cmd_done = sck_rise && phase == eeprom_pkg::PH_CMD &&
		in_cnt == `CMD_LAST;
	assign addr_done = sck_rise && phase == eeprom_pkg::PH_ADDR &&
		in_cnt == `ADDR_LAST;
	assign byte_in  = sck_rise && phase == eeprom_pkg::PH_WDATA &&
		in_cnt == `BYTE_LAST;
	assign busy     = kind != eeprom_pkg::WK_NONE;

	// command decode into the next phase
	always_comb begin
		next_phase = eeprom_pkg::PH_SKIP;
		if (busy && op != `OP_STATE_READ)
			next_phase = eeprom_pkg::PH_SKIP;
		else begin
			case (op)
				`OP_STATE_READ:
					next_phase = eeprom_pkg::PH_STAT;
				`OP_ARRAY_READ:
					next_phase = eeprom_pkg::PH_ADDR;
				`OP_ARRAY_WRITE:
					next_phase = write_latch ? eeprom_pkg::PH_ADDR
						: eeprom_pkg::PH_SKIP;
				`OP_STATE_WRITE:
					next_phase = (write_latch && !hw_guard)
						? eeprom_pkg::PH_SDATA : eeprom_pkg::PH_SKIP;
				// latch commands and unknown codes end here
				default:
					next_phase = eeprom_pkg::PH_SKIP;
			endcase
		end
	end

	// serial position; deselect always returns to command
	always_ff @(posedge ref_clk) begin
		if (rst || !selected) begin
			phase  <= eeprom_pkg::PH_CMD;
			in_cnt <= 4'h0;
			sr     <= 16'h0000;
		end else if (sck_rise) begin
			sr     <= next_sr;
			in_cnt <= in_cnt + 4'h1;
			unique case (phase)
				eeprom_pkg::PH_CMD: if (in_cnt == `CMD_LAST) begin
					in_cnt <= 4'h0;
					phase  <= next_phase;
				end
				eeprom_pkg::PH_ADDR: if (in_cnt == `ADDR_LAST) begin
					in_cnt <= 4'h0;
					phase  <= is_read ? eeprom_pkg::PH_READ
						: eeprom_pkg::PH_WDATA;
				end
				eeprom_pkg::PH_WDATA, eeprom_pkg::PH_SDATA:
					if (in_cnt == `BYTE_LAST)
						in_cnt <= 4'h0;
				eeprom_pkg::PH_READ, eeprom_pkg::PH_STAT,
				eeprom_pkg::PH_SKIP:
					in_cnt <= 4'h0;
			endcase
		end
	end

	// per-period flags, dropped at deselect
	always_ff @(posedge ref_clk) begin
		if (rst || !selected) begin
			is_read  <= 1'b0;
			cmd_write_allow_arm <= 1'b0;
			got_byte <= 1'b0;
			abort    <= 1'b0;
		end else begin
			if (cmd_done) begin
				is_read  <= op == `OP_ARRAY_READ;
				cmd_write_allow_arm <= !busy && op == `OP_WRITE_ALLOW;
			end
			// whole data byte seen
			if (sck_rise && in_cnt == `BYTE_LAST &&
				(phase == eeprom_pkg::PH_WDATA ||
				phase == eeprom_pkg::PH_SDATA))
				got_byte <= 1'b1;
			// guard pin fell before the cycle began
			if (phase == eeprom_pkg::PH_SDATA && hw_guard)
				abort <= 1'b1;
		end
	end

	// programming starts only on deselect after whole bytes
	assign start_array = cs_rise && phase == eeprom_pkg::PH_WDATA &&
		got_byte && in_cnt == 4'h0;
	assign start_status = cs_rise && phase == eeprom_pkg::PH_SDATA &&
		got_byte && in_cnt == 4'h0 && !abort && !hw_guard;
	assign cycle_done = busy && busy_cnt == BW'(1);

	// write latch; completion wins over a late allow
	always_ff @(posedge ref_clk) begin
		if (rst)
			write_latch <= 1'b0;
		else if (cycle_done)
			write_latch <= 1'b0;
		else if (cmd_done && !busy && op == `OP_WRITE_FORBID)
			write_latch <= 1'b0;
		else if (cs_rise && cmd_write_allow_arm)
			write_latch <= 1'b1;
	end

	// incoming status byte, held until the cycle ends
	always_ff @(posedge ref_clk) begin
		if (rst)
			stat_new <= 8'h00;
		else if (sck_rise && phase == eeprom_pkg::PH_SDATA &&
			in_cnt == `BYTE_LAST)
			stat_new <= next_sr[7:0];
	end

	// nonvolatile bits: no reset, they outlive power cycles
	always_ff @(posedge ref_clk) begin
		if (cycle_done && kind == eeprom_pkg::WK_STATUS) begin
			pin_guard_enable <= stat_new[`BIT_GUARD];
			region_sel_hi    <= stat_new[`BIT_SEL_HI];
			region_sel_lo    <= stat_new[`BIT_SEL_LO];
		end
	end

	assign stat = '{guard: pin_guard_enable, rsv: 3'h0,
		sel_hi: region_sel_hi, sel_lo: region_sel_lo,
		latch: write_latch, busy: busy};

	// write address and page mask
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_addr <= '0;
			pmask   <= '0;
		end else begin
			if (cmd_done && op == `OP_ARRAY_WRITE && !busy)
				pmask <= '0;
			if (addr_done && !is_read)
				wr_addr <= next_sr[ADDR_W-1:0];
			if (byte_in) begin
				// a protected byte is taken but never marked
				pmask[wr_addr[PAGE_W-1:0]] <= !is_protected(wr_addr,
					{region_sel_hi, region_sel_lo});
				// upper bits fixed, low six wrap over the page
				wr_addr[PAGE_W-1:0] <= wr_addr[PAGE_W-1:0]
					+ PAGE_W'(1);
			end
		end
	end

	// page buffer; a wrapped address overwrites older data
	always_ff @(posedge ref_clk) begin
		if (byte_in)
			page_mem[wr_addr[PAGE_W-1:0]] <= next_sr[7:0];
	end

	// self-timed cycle; commit walks the page once, early on
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			kind       <= eeprom_pkg::WK_NONE;
			busy_cnt   <= '0;
			commit_idx <= '0;
		end else if (start_array || start_status) begin
			kind       <= start_array ? eeprom_pkg::WK_ARRAY
				: eeprom_pkg::WK_STATUS;
			busy_cnt   <= BW'(WRITE_CYCLES);
			commit_idx <= '0;
		end else if (busy) begin
			busy_cnt <= busy_cnt - BW'(1);
			if (!commit_idx[PAGE_W])
				commit_idx <= commit_idx + (PAGE_W+1)'(1);
			if (cycle_done)
				kind <= eeprom_pkg::WK_NONE;
		end
	end

	assign commit_addr = {wr_addr[ADDR_W-1:PAGE_W],
		commit_idx[PAGE_W-1:0]};

	// array programming, double-checked against the region
	always_ff @(posedge ref_clk) begin
		if (kind == eeprom_pkg::WK_ARRAY && !commit_idx[PAGE_W] &&
			pmask[commit_idx[PAGE_W-1:0]] &&
			!is_protected(commit_addr,
			{region_sel_hi, region_sel_lo}))
			mem[commit_addr] <= page_mem[commit_idx[PAGE_W-1:0]];
	end

	// read pointer runs ahead by the buffer's depth
	always_ff @(posedge ref_clk) begin
		if (rst)
			fetch_addr <= '0;
		else if (addr_done)
			fetch_addr <= next_sr[ADDR_W-1:0];
		else if (phase == eeprom_pkg::PH_READ && buf_push_ok)
			fetch_addr <= fetch_addr + ADDR_W'(1);
	end

	// prefetch buffer: fetch stalls while both slots are full
	pair_buffer #(
		.WIDTH (8),
		.DEPTH (`BUF_DEPTH)
	) u_buf (
		.clk       (ref_clk),
		.rst       (rst),
		.flush     (phase != eeprom_pkg::PH_READ),
		.in_valid  (phase == eeprom_pkg::PH_READ),
		.in_ready  (buf_push_ok),
		.in_data   (mem[fetch_addr]),
		.out_valid (buf_valid),
		.out_ready (buf_pop),
		.out_data  (buf_data)
	);

	assign out_phase = phase == eeprom_pkg::PH_READ ||
		phase == eeprom_pkg::PH_STAT;
	assign buf_pop = sck_fall && phase == eeprom_pkg::PH_READ &&
		out_cnt == 3'h0;
	// status is resampled for every byte so busy can be polled
	assign load_byte = (phase == eeprom_pkg::PH_STAT) ? stat
		: (buf_valid ? buf_data : 8'h00);

	// output shifter, msb first, moves on falling edges
	always_ff @(posedge ref_clk) begin
		if (rst || !selected) begin
			out_cnt <= 3'h0;
			out_sr  <= 7'h00;
			so      <= 1'b0;
		end else if (sck_fall && out_phase) begin
			out_cnt <= out_cnt + 3'h1;
			if (out_cnt == 3'h0) begin
				so     <= load_byte[7];
				out_sr <= load_byte[6:0];
			end else begin
				so     <= out_sr[6];
				out_sr <= {out_sr[5:0], 1'b0};
			end
		end
	end

	// drive only when selected, not paused, and answering
	always_ff @(posedge ref_clk) begin
		if (rst)
			so_oe <= 1'b0;
		else
			so_oe <= selected && !paused && out_phase;
	end

endmodule // spi_eeprom_command_protect
